// ### logic/temp_conversion_limit_monitor.sv
// Conversion sequencer, result register and over-temperature monitor
// Operation
// - Automatic mode restarts a conversion whenever the 800 ms countdown expires.
// - Between conversions only the interval counter runs; timeout raises wake-up.
// - Each wake-up first runs a 4 us settle timer.
// - Then 25 us of conversion, after which the result register loads.
// - Writing one-shot as 1 starts a conversion right after the write completes.
// - One-shot: hold 4 us after write end, result 25 us later.
// - Upper limit is an 8-bit read/write register compared with each result.
// - Result above upper limit with alert enabled activates the alert output.
// - Writing 1 to the alert-reset bit deactivates the alert output.
// - Result below the lower limit also deactivates the alert output.
// - Alert output serves as an open-drain SMBus alert toward the host.
// - Config gives power-down, filter bypass, alert enable and alert polarity.
// - Results are stored as 10-bit two's complement codes.
// - One code step equals 0.25 degrees Celsius.
// - Codes follow sample encodings; positive temperature is code over four.
// - Config bit7 power-down, bit6 filter, bit5 alert off, bit4 polarity.
// - Bits 3 and 2 act on a written 1, are not stored, read zero.
// - One-shot in power-down converts once, then stays powered down.
// - Only the two low pointer bits select the target register.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module temp_conversion_limit_monitor
  import temp_monitor_pkg::*;
#(
  parameter int INTERVAL_COUNT = INTERVAL_CYCLES
)(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter front end
  input wire logic [9:0] sampleCode,
  input wire logic sampleStrobe,
  output logic sampleHold,
  output logic wakeUp,
  // Over-temperature pin, open drain, and bus line filter enable
  output logic alertOut,
  output logic alertOutEn,
  output logic busLineFilterEnable
);

  ////////////////////////////////////////////////////////////////////////////
  // Sample strobe from the front-end clock domain
  // Every pointer value aliases onto the four registers, so the strobe has no
  // register of its own; it stays synchronised for a later status view

  pin_sync u_sample_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .pinIn(sampleStrobe),
    .level(),
    .rise()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic wrPend;
  logic rdPend;
  logic [7:0] addrPend;
  logic next_wrPend;
  logic next_rdPend;
  logic [7:0] next_addrPend;
  logic addrPhase;

  assign addrPhase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Every transfer completes in one data phase, response always OKAY
  always_comb begin
    next_wrPend = wrPend;
    next_rdPend = rdPend;
    next_addrPend = addrPend;
    if (clkEn && hready) begin
      next_wrPend = addrPhase & hwrite;
      next_rdPend = addrPhase & ~hwrite;
      next_addrPend = haddr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      addrPend <= 8'h00;
    end else begin
      wrPend <= next_wrPend;
      rdPend <= next_rdPend;
      addrPend <= next_addrPend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  config_s cfg;
  config_s next_cfg;
  logic [7:0] upperLimit;
  logic [7:0] lowerLimit;
  logic [9:0] result;
  logic [7:0] next_upperLimit;
  logic [7:0] next_lowerLimit;
  logic [9:0] next_result;
  logic [1:0] regSel;
  logic regHit;
  logic cfgWrite;
  logic oneShotReq;
  logic alertResetReq;
  logic convDone;

  // Only the two low index bits pick a register; others alias
  assign regSel = addrPend[3:2];
  assign regHit = (addrPend[1:0] == 2'h0);
  assign cfgWrite = clkEn & wrPend & regHit & (regSel == IDX_CONFIG);
  assign oneShotReq = cfgWrite & hwdata[CFG_ONE_SHOT];
  assign alertResetReq = cfgWrite & hwdata[CFG_ALERT_RESET];

  // Writes; the result register is read-only
  always_comb begin
    next_cfg = cfg;
    next_upperLimit = upperLimit;
    next_lowerLimit = lowerLimit;
    next_result = result;
    if (clkEn && wrPend && regHit) begin
      unique case (regSel)
        IDX_CONFIG: begin
          next_cfg.fullPowerDown = hwdata[CFG_POWER_DOWN];
          next_cfg.busLineFilterEnable = hwdata[CFG_FILTER];
          next_cfg.alertDisable = hwdata[CFG_ALERT_DIS];
          next_cfg.alertActiveHigh = hwdata[CFG_ALERT_POL];
          next_cfg.testMode = hwdata[CFG_TEST_LSB +: 2];
        end
        IDX_UPPER: next_upperLimit = hwdata[7:0];
        IDX_LOWER: next_lowerLimit = hwdata[7:0];
        IDX_RESULT: ;
      endcase
    end
    if (convDone) begin
      next_result = sampleCode;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= config_s'({CONFIG_RESET[7:4], CONFIG_RESET[1:0]});
      upperLimit <= UPPER_RESET;
      lowerLimit <= LOWER_RESET;
      result <= RESULT_RESET;
    end else begin
      cfg <= next_cfg;
      upperLimit <= next_upperLimit;
      lowerLimit <= next_lowerLimit;
      result <= next_result;
    end
  end

  assign busLineFilterEnable = cfg.busLineFilterEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  seq_state_e state;
  seq_state_e next_state;
  logic [31:0] intervalCnt;
  logic [31:0] next_intervalCnt;
  logic [12:0] phaseCnt;
  logic [12:0] next_phaseCnt;
  logic intervalDone;

  assign intervalDone = (intervalCnt == 32'(INTERVAL_COUNT - 1));

  // Interval counter runs free in automatic mode, parked in power-down
  always_comb begin
    next_intervalCnt = intervalCnt;
    if (clkEn) begin
      if (cfg.fullPowerDown || intervalDone) begin
        next_intervalCnt = 32'h0000_0000;
      end else begin
        next_intervalCnt = intervalCnt + 32'h0000_0001;
      end
    end
  end

  // Idle, settle, convert; a one-shot while busy is dropped
  always_comb begin
    next_state = state;
    next_phaseCnt = phaseCnt;
    convDone = 1'b0;
    if (clkEn) begin
      unique case (state)
        SEQ_IDLE: begin
          // Data-phase write is the transaction end: start right away
          if (oneShotReq || (intervalDone && !cfg.fullPowerDown)) begin
            next_state = SEQ_SETTLE;
            next_phaseCnt = 13'h0000;
          end
        end
        SEQ_SETTLE: begin
          if (phaseCnt == 13'(SETTLE_CYCLES - 1)) begin
            next_state = SEQ_CONVERT;
            next_phaseCnt = 13'h0000;
          end else begin
            next_phaseCnt = phaseCnt + 13'h0001;
          end
        end
        SEQ_CONVERT: begin
          if (phaseCnt == 13'(CONVERT_CYCLES - 1)) begin
            next_state = SEQ_IDLE;
            convDone = 1'b1;
          end else begin
            next_phaseCnt = phaseCnt + 13'h0001;
          end
        end
        default: next_state = SEQ_IDLE;
      endcase
    end
  end // oneShotReq ignored outside SEQ_IDLE

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SEQ_IDLE;
      phaseCnt <= 13'h0000;
      intervalCnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      phaseCnt <= next_phaseCnt;
      intervalCnt <= next_intervalCnt;
    end
  end

  // Power-up after wake-up; power-down resumes on return to idle
  assign wakeUp = (state != SEQ_IDLE);
  assign sampleHold = (state == SEQ_CONVERT);

  ////////////////////////////////////////////////////////////////////////////
  // Over-temperature indicator
  logic alertActive;
  logic next_alertActive;
  logic signed [9:0] upperCode;
  logic signed [9:0] lowerCode;

  // Limits are whole degrees; scale to quarter-degree codes for comparison
  assign upperCode = {upperLimit, 2'b00};
  assign lowerCode = {lowerLimit, 2'b00};

  always_comb begin
    next_alertActive = alertActive;
    if (clkEn) begin
      if (alertResetReq) begin
        next_alertActive = 1'b0;
      end
      if (convDone) begin
        if ($signed(sampleCode) > upperCode) begin
          next_alertActive = 1'b1;
        end else if ($signed(sampleCode) < lowerCode) begin
          next_alertActive = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alertActive <= 1'b0;
    end else begin
      alertActive <= next_alertActive;
    end
  end

  // Open drain: only the low level is driven; polarity and enable applied here
  logic alertLevel;
  assign alertLevel = cfg.alertActiveHigh ? (alertActive & ~cfg.alertDisable)
                                          : ~(alertActive & ~cfg.alertDisable);
  assign alertOut = 1'b0;
  assign alertOutEn = ~alertLevel;

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the address phase for the data phase
  logic [31:0] readWord;
  logic [31:0] next_hrdata;

  always_comb begin
    readWord = 32'h0000_0000;
    // Upper pointer bits are ignored, matching the write side
    if (haddr[1:0] == 2'h0) begin
      unique case (haddr[3:2])
        IDX_RESULT: readWord = {22'h000000, result};
        IDX_CONFIG: readWord = {24'h000000, cfg.fullPowerDown, cfg.busLineFilterEnable,
                                cfg.alertDisable, cfg.alertActiveHigh, 2'b00,
                                cfg.testMode};
        IDX_UPPER: readWord = {24'h000000, upperLimit};
        IDX_LOWER: readWord = {24'h000000, lowerLimit};
      endcase
    end
    next_hrdata = hrdata;
    if (clkEn && addrPhase && !hwrite) begin
      next_hrdata = readWord;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule // temp_conversion_limit_monitor

// ### logic/temp_monitor_pkg.sv
// Package: register map, field positions, reset values and timing counts
package temp_monitor_pkg;

  // Register index from the two low pointer bits, byte address is four times it
  localparam logic [1:0] IDX_RESULT = 2'h0;
  localparam logic [1:0] IDX_CONFIG = 2'h1;
  localparam logic [1:0] IDX_UPPER = 2'h2;
  localparam logic [1:0] IDX_LOWER = 2'h3;
  localparam logic [7:0] ADDR_RESULT = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_UPPER = 8'h08;
  localparam logic [7:0] ADDR_LOWER = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Configuration field positions
  localparam int CFG_POWER_DOWN = 7;
  localparam int CFG_FILTER = 6;
  localparam int CFG_ALERT_DIS = 5;
  localparam int CFG_ALERT_POL = 4;
  localparam int CFG_ALERT_RESET = 3;
  localparam int CFG_ONE_SHOT = 2;
  localparam int CFG_TEST_LSB = 0;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h40;
  localparam logic [7:0] UPPER_RESET = 8'h7f;
  localparam logic [7:0] LOWER_RESET = 8'h80;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam int RESULT_WIDTH = 10;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int INTERVAL_MS = 800;
  localparam int SETTLE_US = 4;
  localparam int CONVERT_US = 25;
  localparam int INTERVAL_CYCLES = INTERVAL_MS * 1000 * CLK_MHZ;
  localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
  localparam int CONVERT_CYCLES = CONVERT_US * CLK_MHZ;

  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SETTLE,
    SEQ_CONVERT
  } seq_state_e;

  // Decoded configuration
  typedef struct packed {
    logic fullPowerDown;
    logic busLineFilterEnable;
    logic alertDisable;
    logic alertActiveHigh;
    logic [1:0] testMode;
  } config_s;

endpackage

// ### logic/pin_sync.sv
// Two-stage synchroniser with edge detection on the second stage
`timescale 1ns/1ps
module pin_sync
  import temp_monitor_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Pin and results
  input wire logic pinIn,
  output logic level,
  output logic rise
);

  logic stage1;
  logic stage2;
  logic stage3;
  logic next_stage1;
  logic next_stage2;
  logic next_stage3;

  // Next values; stage1 is read only by stage2
  always_comb begin
    next_stage1 = clkEn ? pinIn : stage1;
    next_stage2 = clkEn ? stage1 : stage2;
    next_stage3 = clkEn ? stage2 : stage3;
  end

  // Register the chain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
      stage3 <= next_stage3;
    end
  end

  assign level = stage2;
  assign rise = stage2 & ~stage3;

endmodule // pin_sync

// ### verification/temp_monitor_props.sv
// Checker: bus response, sequencer phase lengths and filter-enable tracking
`timescale 1ns/1ps
module temp_monitor_props
  import temp_monitor_pkg::*;
#(
  parameter int INTERVAL_COUNT = INTERVAL_CYCLES
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // Bus
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Sequencer and pins
  input wire logic sampleHold,
  input wire logic wakeUp,
  input wire logic alertOut,
  input wire logic busLineFilterEnable
);
  logic cfgWr, next_cfgWr;
  logic [15:0] settleCnt, next_settleCnt, holdCnt, next_holdCnt;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////
  // Config data phase flag; counters sized for the full-length phases
  always_comb begin
    // Only the low index bits select, so every alias of the config word counts
    next_cfgWr = hsel && hready && htrans[1] && hwrite && clkEn
      && (haddr[3:0] == ADDR_CONFIG[3:0]);
    // Phase counters stall with the clock enable, as the sequencer does
    next_settleCnt = !wakeUp ? 16'h0
      : ((sampleHold || !clkEn) ? settleCnt : settleCnt + 16'h1);
    next_holdCnt = !sampleHold ? 16'h0 : (clkEn ? holdCnt + 16'h1 : holdCnt);
  end
  // Helper registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgWr <= 1'h0;
      settleCnt <= 16'h0;
      holdCnt <= 16'h0;
    end else begin
      cfgWr <= next_cfgWr;
      settleCnt <= next_settleCnt;
      holdCnt <= next_holdCnt;
    end
  end
  //////////////////////////////
  sequence oneShotReq;
    cfgWr && clkEn && hwdata[CFG_ONE_SHOT] && !wakeUp;
  endsequence
  sequence settleRun;
    (wakeUp && !sampleHold) [*8];
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_okay_resp: assert property (!hresp) else $error("hresp not okay");
  a_alert_drain: assert property (!alertOut) else $error("alert pin driven high");
  a_hold_in_wake: assert property (sampleHold |-> wakeUp)
    else $error("hold outside wake-up");
  a_oneshot_start: assert property (oneShotReq |=> settleRun)
    else $error("one-shot did not start settle");
  a_wake_settles: assert property ($rose(wakeUp) |-> !sampleHold)
    else $error("wake-up skipped settle");
  a_settle_len: assert property ($rose(sampleHold) |-> settleCnt == SETTLE_CYCLES)
    else $error("settle length wrong");
  a_convert_len: assert property ($fell(sampleHold) |-> !wakeUp && holdCnt == CONVERT_CYCLES)
    else $error("convert length wrong");
  a_filter_load: assert property (cfgWr && clkEn |=>
    busLineFilterEnable == $past(hwdata[CFG_FILTER])) else $error("filter bit not loaded");
  a_filter_hold: assert property (!(cfgWr && clkEn) |=> $stable(busLineFilterEnable))
    else $error("filter bit moved");
endmodule // temp_monitor_props

bind temp_conversion_limit_monitor temp_monitor_props #(.INTERVAL_COUNT(INTERVAL_COUNT)) props_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sampleHold(sampleHold), .wakeUp(wakeUp),
  .alertOut(alertOut), .busLineFilterEnable(busLineFilterEnable));

// ### verification/front_end_model.sv
// Converter front-end model: code while woken, strobe at the link rate
`timescale 1ns/1ps
module front_end_model
  import temp_monitor_pkg::*;
(
  // From the block
  input wire logic wakeUp,
  // From the bench
  input wire logic [9:0] code,
  // To the block
  output logic [9:0] sampleCode,
  output logic sampleStrobe
);
  // Unpowered front end shows the inverse, so stale codes cannot pass
  assign sampleCode = wakeUp ? code : ~code;
  // Strobe stands still between conversions
  initial sampleStrobe = 1'h0;
  always #32 if (wakeUp) sampleStrobe = ~sampleStrobe;
endmodule // front_end_model

// ### verification/tb_top.sv
// Testbench: registers, one-shot timing, alert handling and automatic mode
`timescale 1ns/1ps
module tb_top
  import temp_monitor_pkg::*;
;
  localparam int INTERVAL = 12000;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic clkEn = 1'h1;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [9:0] code = 10'h000;
  logic [31:0] hrdata, tmp;
  logic [9:0] sampleCode;
  logic hready, hreadyout, hresp, sampleStrobe, sampleHold, wakeUp;
  logic alertOut, alertOutEn, busLineFilterEnable;
  int nFail = 0;
  int nChecks = 0;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // 250 MHz clock
  always #2 ref_clk = ~ref_clk;
  temp_conversion_limit_monitor #(.INTERVAL_COUNT(INTERVAL)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sampleCode(sampleCode),
    .sampleStrobe(sampleStrobe), .sampleHold(sampleHold), .wakeUp(wakeUp),
    .alertOut(alertOut), .alertOutEn(alertOutEn), .busLineFilterEnable(busLineFilterEnable));
  front_end_model fe_u (.wakeUp(wakeUp), .code(code), .sampleCode(sampleCode),
    .sampleStrobe(sampleStrobe));
  //////////////////////////////
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      nFail++;
    end
  endtask
  // Single word transfer; held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'h1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'h1);
    r = hrdata;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d, tmp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(a, 1'h0, 32'h0, tmp);
    chk(nm, exp, tmp);
  endtask
  // Bounded wait, leaves us just after an edge unless the level is already there on entry
  task automatic waitFor(ref logic s, input logic lvl, input int lim);
    for (int k = 0; k < lim && s !== lvl; k++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask
  //////////////////////////////
  task automatic resetValues();
    rd(ADDR_RESULT, {22'h0, RESULT_RESET}, "result");
    rd(ADDR_CONFIG, {24'h0, CONFIG_RESET}, "config");
    rd(ADDR_UPPER, {24'h0, UPPER_RESET}, "upper");
    rd(ADDR_LOWER, {24'h0, LOWER_RESET}, "lower");
    chk("filter", 32'h1, busLineFilterEnable);
    chk("alertOutEn", 32'h0, alertOutEn);
  endtask
  task automatic regAccess();
    wr(ADDR_CONFIG, 32'h88);
    chk("filter", 32'h0, busLineFilterEnable);
    rd(ADDR_CONFIG, 32'h80, "config pulses");
    wr(ADDR_UPPER, 32'h19);
    rd(ADDR_UPPER, 32'h19, "upper");
    wr(ADDR_LOWER, 32'h14);
    rd(ADDR_LOWER, 32'h14, "lower");
    wr(ADDR_RESULT, 32'h155);
    rd(ADDR_RESULT, 32'h0, "result ro");
    // Index 5 keeps only its two low bits, so it lands on the configuration
    rd(8'h14, 32'h80, "alias");
  endtask
  // Settle length measured in cycles from the wake-up, convert length from the start of the hold
  task automatic oneShot(input logic [7:0] cfg, input logic [9:0] c, input logic twice);
    realtime t0;
    code <= c;
    wr(ADDR_CONFIG, {24'h0, cfg | 8'h04});
    chk("wake", 32'h1, wakeUp);
    t0 = $realtime;
    if (twice) wr(ADDR_CONFIG, {24'h0, cfg | 8'h04});
    waitFor(sampleHold, 1'h1, 2000);
    chk("settle", SETTLE_CYCLES, int'(($realtime - t0) / 4.0));
    t0 = $realtime;
    waitFor(wakeUp, 1'h0, 8000);
    chk("convert", CONVERT_CYCLES, int'(($realtime - t0) / 4.0));
    rd(ADDR_RESULT, {22'h0, c}, "result");
  endtask
  task automatic alertFlow();
    oneShot(8'hc0, 10'h065, 1'h1);
    chk("alert set", 32'h1, alertOutEn);
    rd(ADDR_CONFIG, 32'hc0, "config after");
    repeat (50) @(posedge ref_clk);
    chk("stays down", 32'h0, wakeUp);
    wr(ADDR_CONFIG, 32'hc8);
    repeat (2) @(posedge ref_clk);
    chk("alert reset", 32'h0, alertOutEn);
    oneShot(8'hd0, 10'h065, 1'h0);
    chk("active high", 32'h0, alertOutEn);
    wr(ADDR_CONFIG, 32'hc0);
    repeat (2) @(posedge ref_clk);
    chk("active low", 32'h1, alertOutEn);
    oneShot(8'hc0, 10'h04f, 1'h0);
    chk("below lower", 32'h0, alertOutEn);
    oneShot(8'he0, 10'h1f4, 1'h0);
    chk("disabled", 32'h0, alertOutEn);
  endtask
  // Clock enable low for 100 cycles must stretch the settle phase by exactly that
  task automatic freeze();
    realtime t0;
    wr(ADDR_CONFIG, 32'hc4);
    t0 = $realtime;
    clkEn <= 1'h0;
    repeat (100) @(posedge ref_clk);
    clkEn <= 1'h1;
    waitFor(sampleHold, 1'h1, 2000);
    chk("frozen settle", SETTLE_CYCLES + 100, int'(($realtime - t0) / 4.0));
    waitFor(wakeUp, 1'h0, 8000);
    chk("frozen done", 32'h0, wakeUp);
  endtask
  task automatic autoMode();
    realtime t0;
    code <= 10'h3ff;
    wr(ADDR_CONFIG, 32'h40);
    waitFor(wakeUp, 1'h1, INTERVAL + 10);
    t0 = $realtime;
    waitFor(wakeUp, 1'h0, 8000);
    waitFor(wakeUp, 1'h1, INTERVAL + 10);
    chk("interval", INTERVAL, int'(($realtime - t0) / 4.0));
    rd(ADDR_RESULT, 32'h3ff, "negative code");
    // Drop the sign bit, take 512 off: the answer is in quarter degrees
    chk("decoded", 32'hffff_ffff, 32'(int'(tmp[8:0]) - 512));
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  //////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    resetValues();
    regAccess();
    alertFlow();
    freeze();
    autoMode();
    conclude();
  end
  // Watchdog near 90000 cycles; the tests need about 60500
  initial begin
    #360000;
    nFail++;
    conclude();
  end
endmodule // tb_top
